// ---- core/psumg_top.sv ----
// Supply card management: output switching, status pins, telemetry slave.
// Assumes all pin inputs are asynchronous; telemetry comes from core logic.
module psumg_top (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_inhibit_n,
    input wire logic i_enable_n,
    input wire logic [4:0] i_slot_id_pins_n,
    input wire logic i_slot_id_parity_n,
    input wire logic i_main_fault,
    input wire logic i_aux_fault,
    input wire logic i_main_in_reg,
    input wire logic i_aux_in_reg,
    input wire logic i_input_lost,
    input wire psumg_pkg::psumg_mode_t i_mgmt_mode,
    input wire psumg_pkg::psumg_telem_t i_telem,
    input wire logic i_scl_i,
    output logic o_scl_o,
    output logic o_scl_oe,
    input wire logic i_sda_i,
    output logic o_sda_o,
    output logic o_sda_oe,
    output logic o_main_on,
    output logic o_aux_low_rail,
    output logic o_fail_n,
    output logic o_outputs_in_regulation_n,
    output logic o_alert_n,
    output logic [6:0] o_dev_addr
);
    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    psumg_pkg::psumg_pins_t pin_raw;
    psumg_pkg::psumg_pins_t pin_s;

    assign pin_raw = '{i_scl_i, i_sda_i, i_inhibit_n, i_enable_n,
        i_slot_id_parity_n, i_slot_id_pins_n, i_main_fault, i_aux_fault,
        i_main_in_reg, i_aux_in_reg, i_input_lost};

    // Filter delay of a few cycles is far below a 200 kHz half period
    psumg_sync #(
        .W(psumg_pkg::PSUMG_PIN_W),
        .RST_VAL(psumg_pkg::PSUMG_PIN_RST)
    ) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_d(pin_raw),
        .o_q(pin_s)
    );

    // ------------------------------------------------------------
    // Output switching and status pins
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_main_on <= 1'b0;
            o_aux_low_rail <= 1'b0;
        end else begin
            o_main_on <= pin_s.inhibit_n & ~pin_s.enable_n;
            o_aux_low_rail <= ~pin_s.enable_n;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_fail_n <= 1'b1;
            o_outputs_in_regulation_n <= 1'b1;
            o_alert_n <= 1'b1;
        end else begin
            o_fail_n <= ~(pin_s.main_fault | pin_s.aux_fault);
            o_outputs_in_regulation_n <=
                ~(pin_s.main_in_reg & pin_s.aux_in_reg);
            o_alert_n <= ~pin_s.input_lost;
        end
    end

    // ------------------------------------------------------------
    // Slot address capture
    // ------------------------------------------------------------
    logic [2:0] cap_cnt_r;
    logic addr_valid_r;

    // Wait for the synchroniser to fill before trusting the straps
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cap_cnt_r <= 3'h0;
            addr_valid_r <= 1'b0;
            o_dev_addr <= psumg_pkg::PSUMG_ADDR_RST;
        end else if (!addr_valid_r) begin
            cap_cnt_r <= cap_cnt_r + 3'h1;
            if (cap_cnt_r == psumg_pkg::PSUMG_CAP_WAIT) begin
                addr_valid_r <= 1'b1;
                o_dev_addr <= {psumg_pkg::PSUMG_ADDR_MSB,
                    ~pin_s.slot_id_parity_n,
                    ~pin_s.slot_id_pins_n};
            end
        end
    end

    // ------------------------------------------------------------
    // Response block
    // ------------------------------------------------------------
    function automatic logic [7:0] resp_byte(
        input psumg_pkg::psumg_telem_t t,
        input logic [7:0] cmd,
        input logic [5:0] i
    );
        logic [5:0] k;
        logic [15:0] w;
        int j;
        k = 6'h0;
        w = 16'h0;
        j = 0;
        resp_byte = 8'h00;
        if (i == psumg_pkg::PSUMG_IDX_ECHO) begin
            resp_byte = cmd;
        end else if (i == psumg_pkg::PSUMG_IDX_TEMP) begin
            resp_byte = t.temp;
        end else if (i >= psumg_pkg::PSUMG_IDX_VOLT &&
                     i < psumg_pkg::PSUMG_IDX_RSVD) begin
            if (i < psumg_pkg::PSUMG_IDX_CURR) begin
                k = i - psumg_pkg::PSUMG_IDX_VOLT;
                w = t.volt[k[3:1]];
            end else begin
                k = i - psumg_pkg::PSUMG_IDX_CURR;
                w = t.curr[k[3:1]];
            end
            resp_byte = k[0] ? w[7:0] : w[15:8];
        end else if (i >= psumg_pkg::PSUMG_IDX_PART &&
                     i < psumg_pkg::PSUMG_IDX_IDENT) begin
            j = 19 - int'(i - psumg_pkg::PSUMG_IDX_PART);
            resp_byte = psumg_pkg::PSUMG_PART_STR[8*j +: 8];
        end else if (i >= psumg_pkg::PSUMG_IDX_IDENT &&
                     i < psumg_pkg::PSUMG_IDX_FIXED) begin
            j = 9 - int'(i - psumg_pkg::PSUMG_IDX_IDENT);
            resp_byte = psumg_pkg::PSUMG_IDENT[8*j +: 8];
        end else if (i == psumg_pkg::PSUMG_IDX_FIXED) begin
            resp_byte = psumg_pkg::PSUMG_FIXED_BYTE;
        end
    endfunction

    psumg_pkg::psumg_telem_t snap_r;
    logic [7:0] cmd_r;
    logic [7:0] csum_r;
    logic [7:0] sum_acc;

    // Sum over bytes 0 to 62 of the frozen snapshot
    always_comb begin
        sum_acc = 8'h00;
        for (int n = 0; n < 63; n++) begin
            sum_acc = sum_acc + resp_byte(snap_r, cmd_r, 6'(n));
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            csum_r <= 8'h00;
        end else begin
            csum_r <= 8'h00 - sum_acc;
        end
    end

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    psumg_pkg::psumg_state_t st_r;
    logic scl_q;
    logic sda_q;
    logic [3:0] cnt_r;
    logic [7:0] sh_r;
    logic rw_r;
    logic [1:0] wr_idx_r;
    logic acc_r;
    logic [5:0] rd_idx_r;
    logic i2c_on;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic [7:0] cur_byte;

    assign i2c_on = (i_mgmt_mode == psumg_pkg::PSUMG_MODE_I2C)
        && addr_valid_r;
    assign scl_rise = pin_s.scl & ~scl_q;
    assign scl_fall = ~pin_s.scl & scl_q;
    assign bus_start = pin_s.scl & scl_q & sda_q & ~pin_s.sda;
    assign bus_stop = pin_s.scl & scl_q & ~sda_q & pin_s.sda;
    // Reads without an accepted command return all ones
    assign cur_byte = !acc_r ? psumg_pkg::PSUMG_IDLE_BYTE :
        (rd_idx_r == psumg_pkg::PSUMG_IDX_CSUM) ? csum_r :
        resp_byte(snap_r, cmd_r, rd_idx_r);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            o_scl_o <= 1'b0;
            o_scl_oe <= 1'b0;
            o_sda_o <= 1'b0;
        end else begin
            scl_q <= pin_s.scl;
            sda_q <= pin_s.sda;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r <= psumg_pkg::PSUMG_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            rw_r <= 1'b0;
            wr_idx_r <= 2'h0;
            acc_r <= 1'b0;
            cmd_r <= 8'h00;
            snap_r <= '0;
            rd_idx_r <= 6'h0;
            o_sda_oe <= 1'b0;
        end else if (!i2c_on) begin
            st_r <= psumg_pkg::PSUMG_IDLE;
            o_sda_oe <= 1'b0;
        end else if (bus_start) begin
            st_r <= psumg_pkg::PSUMG_ADDR;
            cnt_r <= 4'h0;
            wr_idx_r <= 2'h0;
            o_sda_oe <= 1'b0;
        end else if (bus_stop) begin
            st_r <= psumg_pkg::PSUMG_IDLE;
            o_sda_oe <= 1'b0;
        end else begin
            unique case (st_r)
                psumg_pkg::PSUMG_IDLE: begin
                end
                psumg_pkg::PSUMG_ADDR,
                psumg_pkg::PSUMG_WR_BYTE: begin
                    if (scl_rise) begin
                        sh_r <= {sh_r[6:0], pin_s.sda};
                        cnt_r <= cnt_r + 4'h1;
                    end else if (scl_fall &&
                                 cnt_r == psumg_pkg::PSUMG_BITS_PER_BYTE) begin
                        if (st_r == psumg_pkg::PSUMG_ADDR) begin
                            if (sh_r[7:1] == o_dev_addr) begin
                                st_r <= psumg_pkg::PSUMG_ADDR_ACK;
                                rw_r <= sh_r[0];
                                // Cleared here so the first byte is 0
                                rd_idx_r <= 6'h0;
                                o_sda_oe <= 1'b1;
                            end else begin
                                st_r <= psumg_pkg::PSUMG_IDLE;
                            end
                        end else begin
                            st_r <= psumg_pkg::PSUMG_WR_ACK;
                            // Bytes past the checksum are refused
                            o_sda_oe <= wr_idx_r < psumg_pkg::PSUMG_WR_BYTES;
                            if (wr_idx_r == 2'h0) begin
                                cmd_r <= sh_r;
                                acc_r <= 1'b0;
                            end else if (wr_idx_r == 2'h1 &&
                                         cmd_r == psumg_pkg::PSUMG_CMD_READ &&
                                         8'(cmd_r + sh_r) == 8'h00) begin
                                acc_r <= 1'b1;
                                snap_r <= i_telem;
                            end
                            if (wr_idx_r != 2'h3) begin
                                wr_idx_r <= wr_idx_r + 2'h1;
                            end
                        end
                    end
                end
                psumg_pkg::PSUMG_ADDR_ACK,
                psumg_pkg::PSUMG_WR_ACK: begin
                    if (scl_fall) begin
                        cnt_r <= 4'h0;
                        if (st_r == psumg_pkg::PSUMG_ADDR_ACK && rw_r) begin
                            st_r <= psumg_pkg::PSUMG_RD_BYTE;
                            sh_r <= cur_byte;
                            o_sda_oe <= ~cur_byte[7];
                        end else begin
                            st_r <= psumg_pkg::PSUMG_WR_BYTE;
                            o_sda_oe <= 1'b0;
                        end
                    end
                end
                psumg_pkg::PSUMG_RD_BYTE: begin
                    if (scl_rise) begin
                        cnt_r <= cnt_r + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_r == psumg_pkg::PSUMG_BITS_PER_BYTE) begin
                            st_r <= psumg_pkg::PSUMG_RD_ACK;
                            o_sda_oe <= 1'b0;
                            rd_idx_r <= rd_idx_r + 6'h1;
                        end else begin
                            sh_r <= {sh_r[6:0], 1'b0};
                            o_sda_oe <= ~sh_r[6];
                        end
                    end
                end
                psumg_pkg::PSUMG_RD_ACK: begin
                    if (scl_fall) begin
                        cnt_r <= 4'h0;
                        if (!pin_s.sda) begin
                            st_r <= psumg_pkg::PSUMG_RD_BYTE;
                            sh_r <= cur_byte;
                            o_sda_oe <= ~cur_byte[7];
                        end else begin
                            st_r <= psumg_pkg::PSUMG_IDLE;
                        end
                    end
                end
                default: begin
                    st_r <= psumg_pkg::PSUMG_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_main_rail_decode: assert property (
        !$past(pin_s.inhibit_n) || $past(pin_s.enable_n) |-> !o_main_on
    ) else $error("main rail on with wrong pins");
    a_aux_rail_decode: assert property (
        $changed(pin_s.enable_n) |=> o_aux_low_rail == !$past(pin_s.enable_n)
    ) else $error("aux rail does not follow enable");
    a_fail_pin_low: assert property (
        pin_s.main_fault || pin_s.aux_fault |=> !o_fail_n
    ) else $error("fail not shown");
    a_regulation_pin: assert property (
        !(pin_s.main_in_reg && pin_s.aux_in_reg) |=> o_outputs_in_regulation_n
    ) else $error("regulation shown falsely");
    a_alert_pin_low: assert property (
        pin_s.input_lost ##1 pin_s.input_lost |-> !o_alert_n
    ) else $error("input loss not alerted");
    a_mode_no_drive: assert property (
        i_mgmt_mode != psumg_pkg::PSUMG_MODE_I2C |=> !o_sda_oe
    ) else $error("bus driven outside serial mode");
    a_addr_form: assert property (
        $rose(addr_valid_r) |-> o_dev_addr ==
            {1'b1, ~$past(pin_s.slot_id_parity_n),
             ~$past(pin_s.slot_id_pins_n)}
    ) else $error("slot address wrong");
    a_addr_ack_low: assert property (
        st_r == psumg_pkg::PSUMG_ADDR && scl_fall && !bus_start && !bus_stop
        && i2c_on && cnt_r == 4'h8 && sh_r[7:1] == o_dev_addr
        |=> o_sda_oe && st_r == psumg_pkg::PSUMG_ADDR_ACK
    ) else $error("address not acknowledged");
    a_bad_sum_drop: assert property (
        st_r == psumg_pkg::PSUMG_WR_BYTE && scl_fall && i2c_on && !bus_stop
        && !bus_start && cnt_r == 4'h8 && wr_idx_r == 2'h1
        && 8'(cmd_r + sh_r) != 8'h00 |=> !acc_r
    ) else $error("bad checksum accepted");
    a_echo_first: assert property (
        st_r == psumg_pkg::PSUMG_ADDR_ACK && rw_r && acc_r && scl_fall
        && i2c_on && !bus_start && !bus_stop
        |=> sh_r == cmd_r && rd_idx_r == 6'h0
    ) else $error("first byte not the echo");
    a_csum_zero: assert property (
        acc_r && $stable(snap_r) && $stable(cmd_r) |->
            8'(sum_acc + csum_r) == 8'h00
    ) else $error("checksum does not zero the sum");

    c_cmd_accept: cover property ($rose(acc_r));
    c_read_last: cover property (
        st_r == psumg_pkg::PSUMG_RD_ACK && rd_idx_r == 6'h0 && acc_r);
    c_read_nack: cover property (
        st_r == psumg_pkg::PSUMG_RD_ACK ##1 st_r == psumg_pkg::PSUMG_IDLE);
endmodule // psumg_top

// ---- core/psumg_pkg.sv ----
// Shared constants and carrier types for the supply management block.
// Assumes a single 25 MHz core clock and an asynchronous active-high reset.
package psumg_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int PSUMG_CLK_HZ = 25000000;
    localparam int PSUMG_BUS_MAX_HZ = 200000;
    // Core cycles in the shortest bus clock half period
    localparam int PSUMG_SCL_HALF_CYC =
        PSUMG_CLK_HZ / (2 * PSUMG_BUS_MAX_HZ);
    // Synchroniser output settles at the fourth edge; capture one later
    localparam logic [2:0] PSUMG_CAP_WAIT = 3'h4;

    // ------------------------------------------------------------
    // Addressing and protocol
    // ------------------------------------------------------------
    localparam logic [6:0] PSUMG_ADDR_RST = 7'h40;
    localparam logic PSUMG_ADDR_MSB = 1'h1;
    localparam logic [7:0] PSUMG_CMD_READ = 8'h21;
    localparam logic [7:0] PSUMG_CMD_CHK = 8'hDF;
    localparam logic [3:0] PSUMG_BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] PSUMG_WR_BYTES = 2'h2;
    localparam logic [7:0] PSUMG_IDLE_BYTE = 8'hFF;

    // ------------------------------------------------------------
    // Response layout (byte indices)
    // ------------------------------------------------------------
    localparam logic [5:0] PSUMG_IDX_ECHO = 6'h00;
    localparam logic [5:0] PSUMG_IDX_TEMP = 6'h02;
    localparam logic [5:0] PSUMG_IDX_VOLT = 6'h04;
    localparam logic [5:0] PSUMG_IDX_CURR = 6'h10;
    localparam logic [5:0] PSUMG_IDX_RSVD = 6'h1C;
    localparam logic [5:0] PSUMG_IDX_PART = 6'h20;
    localparam logic [5:0] PSUMG_IDX_IDENT = 6'h34;
    localparam logic [5:0] PSUMG_IDX_FIXED = 6'h3E;
    localparam logic [5:0] PSUMG_IDX_CSUM = 6'h3F;
    localparam logic [7:0] PSUMG_FIXED_BYTE = 8'hAA;
    // Arbitrary neutral part string, padded with zero bytes
    localparam logic [159:0] PSUMG_PART_STR = {"PSUCARD01", 88'h0};
    // Arbitrary serial, date, board and firmware revision digits
    localparam logic [79:0] PSUMG_IDENT = 80'h0000_0001_0000_2D41_1000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PSUMG_MODE_I2C = 2'h0,
        PSUMG_MODE_MC1 = 2'h1,
        PSUMG_MODE_MC2 = 2'h2
    } psumg_mode_t;

    typedef enum logic [2:0] {
        PSUMG_IDLE = 3'h0,
        PSUMG_ADDR = 3'h1,
        PSUMG_ADDR_ACK = 3'h3,
        PSUMG_WR_BYTE = 3'h2,
        PSUMG_WR_ACK = 3'h6,
        PSUMG_RD_BYTE = 3'h7,
        PSUMG_RD_ACK = 3'h5
    } psumg_state_t;

    typedef struct packed {
        logic [7:0] temp;
        logic [5:0][15:0] volt;
        logic [5:0][15:0] curr;
    } psumg_telem_t;

    typedef struct packed {
        logic scl;
        logic sda;
        logic inhibit_n;
        logic enable_n;
        logic slot_id_parity_n;
        logic [4:0] slot_id_pins_n;
        logic main_fault;
        logic aux_fault;
        logic main_in_reg;
        logic aux_in_reg;
        logic input_lost;
    } psumg_pins_t;

    localparam int PSUMG_PIN_W = 15;
    localparam logic [14:0] PSUMG_PIN_RST = 15'h6FE0;

endpackage

// ---- core/psumg_sync.sv ----
// Three-stage input synchroniser with agreement filter.
// Assumes inputs come from outside the core clock domain.
module psumg_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
        end else begin
            s1_r <= i_d;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // A change counts only once the last two stages agree
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_q <= RST_VAL;
        end else begin
            for (int b = 0; b < W; b++) begin
                if (s2_r[b] == s3_r[b]) begin
                    o_q[b] <= s3_r[b];
                end
            end
        end
    end
endmodule // psumg_sync

// ---- tb/psumg_i2c_master.sv ----
// Behavioural bus master that drives the supply management slave.
// Assumes the bench resolves both open-drain wires with pull-ups.
module psumg_i2c_master #(
    parameter int HALF = psumg_pkg::PSUMG_SCL_HALF_CYC + 1
) (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    timeunit 1ns;
    timeprecision 1ps;
    // High means released, so the pull-up sets the wire
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // Data moves mid low phase only; a move while high is a start or stop
    task automatic xbit(input logic b, output logic r);
        wait_cyc(HALF / 2);
        o_sda <= b;
        wait_cyc(HALF - HALF / 2);
        o_scl <= 1'b1;
        wait_cyc(HALF);
        r = i_sda;
        o_scl <= 1'b0;
    endtask
    task automatic start;
        wait_cyc(HALF / 2);
        o_sda <= 1'b1;
        wait_cyc(HALF);
        o_scl <= 1'b1;
        wait_cyc(HALF);
        o_sda <= 1'b0;
        wait_cyc(HALF);
        o_scl <= 1'b0;
    endtask
    task automatic stop;
        wait_cyc(HALF / 2);
        o_sda <= 1'b0;
        wait_cyc(HALF);
        o_scl <= 1'b1;
        wait_cyc(HALF);
        o_sda <= 1'b1;
        wait_cyc(HALF);
    endtask
    task automatic wr(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(d[i], r);
        xbit(1'b1, ack);
    endtask
    // Every byte but the last one is acknowledged
    task automatic rd(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(1'b1, r);
            d[i] = r;
        end
        xbit(last, r);
    endtask
endmodule // psumg_i2c_master

// ---- tb/tb_top.sv ----
// Self-checking bench for the supply management block.
// Assumes the bus master model is the only other party on the wires.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, inh = 1'b0, en = 1'b1, mf = 1'b0;
    logic af = 1'b0, mr = 1'b0, ar = 1'b0, lost = 1'b0, a;
    logic scl_o, scl_oe, sda_o, sda_oe, m_scl, m_sda, main_on, aux;
    logic fail_n, reg_n, alert_n;
    logic [6:0] addr;
    logic [7:0] got [0:63];
    logic [7:0] s;
    psumg_pkg::psumg_mode_t mode = psumg_pkg::PSUMG_MODE_I2C;
    psumg_pkg::psumg_telem_t telem;
    int fail_count = 0, total_checks = 0;
    wire scl = m_scl & ~(scl_oe & ~scl_o);
    wire sda = m_sda & ~(sda_oe & ~sda_o);
    always #20 clk = ~clk;
    // Slot pins fixed from time zero: slot 1, parity pin released
    psumg_top u_psumg_top (.i_clk(clk), .i_rst(rst), .i_inhibit_n(inh),
        .i_enable_n(en), .i_slot_id_pins_n(5'h1E), .i_slot_id_parity_n(1'h1),
        .i_main_fault(mf), .i_aux_fault(af), .i_main_in_reg(mr),
        .i_aux_in_reg(ar), .i_input_lost(lost), .i_mgmt_mode(mode),
        .i_telem(telem), .i_scl_i(scl), .o_scl_o(scl_o), .o_scl_oe(scl_oe),
        .i_sda_i(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_main_on(main_on),
        .o_aux_low_rail(aux), .o_fail_n(fail_n),
        .o_outputs_in_regulation_n(reg_n), .o_alert_n(alert_n),
        .o_dev_addr(addr));
    psumg_i2c_master u_psumg_i2c_master (.i_clk(clk), .i_sda(sda),
        .o_scl(m_scl), .o_sda(m_sda));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic finish_test;
        $display("checks=%0d mismatches=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic cmdw(input logic [7:0] c, input logic [7:0] k);
        u_psumg_i2c_master.start();
        u_psumg_i2c_master.wr({7'h41, 1'b0}, a);
        chk(a, 0);
        u_psumg_i2c_master.wr(c, a);
        chk(a, 0);
        u_psumg_i2c_master.wr(k, a);
        chk(a, 0);
        u_psumg_i2c_master.stop();
    endtask
    task automatic rdn(input int n);
        u_psumg_i2c_master.start();
        u_psumg_i2c_master.wr({7'h41, 1'b1}, a);
        chk(a, 0);
        for (int i = 0; i < n; i++) u_psumg_i2c_master.rd(i == n - 1, got[i]);
        u_psumg_i2c_master.stop();
    endtask
    function automatic logic [7:0] expb(input int i);
        if (i == 0) return psumg_pkg::PSUMG_CMD_READ;
        if (i == 2) return telem.temp;
        if (i >= 4 && i < 16) return 8'(telem.volt[(i-4)/2] >> 8*(1-i%2));
        if (i >= 16 && i < 28) return 8'(telem.curr[(i-16)/2] >> 8*(1-i%2));
        if (i >= 32 && i < 52)
            return 8'(psumg_pkg::PSUMG_PART_STR >> 8*(51-i));
        if (i >= 52 && i < 62) return 8'(psumg_pkg::PSUMG_IDENT >> 8*(61-i));
        if (i == 62) return psumg_pkg::PSUMG_FIXED_BYTE;
        return 8'h00;
    endfunction
    // Watchdog: the full read alone takes about 75k cycles
    initial begin
        repeat (110000) @(posedge clk);
        fail_count++;
        finish_test();
    end
    initial begin
        telem.temp = 8'hC9;
        for (int k = 0; k < 6; k++) begin
            telem.volt[k] = 16'hA1B0 + 16'(k);
            telem.curr[k] = 16'h52C0 + 16'(k);
        end
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        chk({1'b0, addr}, 8'h41);
        chk({6'h0, scl_oe, sda_o}, 8'h00);
        for (int i = 0; i < 128; i++) begin
            {lost, ar, mr, af, mf, en, inh} <= 7'(i);
            repeat (8) @(posedge clk);
            chk({main_on, aux, fail_n, reg_n, alert_n},
                {i[0] & ~i[1], ~i[1], ~(i[2] | i[3]), ~(i[4] & i[5]),
                ~i[6]});
        end
        u_psumg_i2c_master.start();
        u_psumg_i2c_master.wr({7'h40, 1'b0}, a);
        chk(a, 1);
        u_psumg_i2c_master.stop();
        mode <= psumg_pkg::PSUMG_MODE_MC1;
        u_psumg_i2c_master.start();
        u_psumg_i2c_master.wr({7'h41, 1'b0}, a);
        chk(a, 1);
        u_psumg_i2c_master.stop();
        mode <= psumg_pkg::PSUMG_MODE_I2C;
        cmdw(8'h21, 8'h00);
        rdn(1);
        chk(got[0], 8'hFF);
        cmdw(8'h22, 8'hDE);
        rdn(1);
        chk(got[0], 8'hFF);
        cmdw(8'h21, 8'hDF);
        rdn(64);
        s = 8'h00;
        for (int i = 0; i < 64; i++) begin
            if (i < 63) begin
                chk(got[i], expb(i));
            end
            s = s + got[i];
        end
        chk(s, 8'h00);
        finish_test();
    end
endmodule // tb_top
